// ==== common/siwai_defs.svh ====
// constants for the two-wire serial wait, acknowledge and interrupt block
// assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus
`ifndef SIWAI_DEFS_SVH
`define SIWAI_DEFS_SVH

`define SIWAI_IDX_IRQ_SEL    8'h0C
`define SIWAI_IDX_WAIT_CTRL  8'h0E
`define SIWAI_IDX_STATUS     8'h0F
`define SIWAI_IDX_CONFIG     8'h10
`define SIWAI_WORD_SHIFT     2

`define SIWAI_WC_ACK         3
`define SIWAI_WC_REL         2
`define SIWAI_ST_IRQ         0
`define SIWAI_CF_I2C         0
`define SIWAI_CF_MASTER      1
`define SIWAI_CF_TX          2
`define SIWAI_CF_CLKSTOP     3

`define SIWAI_CNT_IRQ7       4'h7
`define SIWAI_CNT_EIGHT      4'h8
`define SIWAI_CNT_I2C_MAX    4'h9
`define SIWAI_CNT_SIO_MAX    4'h8
`define SIWAI_CNT_ZERO       4'h0

`define SIWAI_IRQ_CNT7       2'h0
`define SIWAI_IRQ_CNT8       2'h1
`define SIWAI_IRQ_START7     2'h2
`define SIWAI_IRQ_STOP       2'h3
`define SIWAI_WAIT_DATA      2'h1
`define SIWAI_WAIT_ACK       2'h2
`define SIWAI_WAIT_ADDR      2'h3

`define SIWAI_RESP_OKAY      2'h0
`define SIWAI_RESP_SLVERR    2'h2
`define SIWAI_PIN_IDLE       1'h1

`define SIWAI_CLK_PERIOD_NS  5
`define SIWAI_SCL_HALF_NS    5333

`endif

// ==== common/siwai_pkg.sv ====
// types shared by the serial wait and acknowledge block
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package siwai_pkg;
	typedef enum logic [1:0] {st_wait, st_run, st_force} siwai_wait_t;
	typedef logic [3:0] siwai_count_t;
endpackage : siwai_pkg
`default_nettype wire

// ==== common/siwai_cnt_if.sv ====
// link between the core and its shift clock counter
// assumes both ends run on sys_clk
`default_nettype none
interface siwai_cnt_if
	import siwai_pkg::*;
();
	logic         rise;
	logic         fall;
	logic         run;
	logic         clr;
	logic         i2c;
	siwai_count_t cnt;
	modport ctl (output rise, output fall, output run, output clr, output i2c, input cnt);
	modport counter (input rise, input fall, input run, input clr, input i2c, output cnt);
endinterface : siwai_cnt_if
`default_nettype wire

// ==== rtl/siwai_pin_sync.sv ====
// two-flop synchronisers with edge detection for external pins
// assumes pins idle high and are asynchronous to sys_clk
`default_nettype none
`include "siwai_defs.svh"
module siwai_pin_sync #(
	parameter int W = 2
) (
	input  wire logic         sys_clk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] lvl,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic meta_q;
		logic sync_q;
		logic prev_q;
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				meta_q <= `SIWAI_PIN_IDLE;
				sync_q <= `SIWAI_PIN_IDLE;
				prev_q <= `SIWAI_PIN_IDLE;
			end else if (ce) begin
				meta_q <= pin_i[i];
				sync_q <= meta_q;
				prev_q <= sync_q;
			end
		end
		assign lvl[i]  = sync_q;
		assign rise[i] = sync_q & ~prev_q;
		assign fall[i] = ~sync_q & prev_q;
	end
endmodule : siwai_pin_sync
`default_nettype wire

// ==== rtl/siwai_clk_counter.sv ====
// shift clock counter: counts rises while running, wraps at the mode limit
// assumes rise and fall are single-cycle events from synchronised pins
`default_nettype none
`include "siwai_defs.svh"
module siwai_clk_counter
	import siwai_pkg::*;
(
	input  wire logic     sys_clk,
	input  wire logic     rst,
	input  wire logic     ce,
	siwai_cnt_if.counter  cif
);
	siwai_count_t cnt_q;
	wire siwai_count_t cnt_max = cif.i2c ? `SIWAI_CNT_I2C_MAX : `SIWAI_CNT_SIO_MAX;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= `SIWAI_CNT_ZERO;
		end else if (ce) begin
			if (cif.clr) begin
				cnt_q <= `SIWAI_CNT_ZERO;
			end else if (cif.run && cif.rise && cnt_q != cnt_max) begin
				cnt_q <= cnt_q + 4'h1;
			end else if (cif.run && cif.fall && cnt_q == cnt_max) begin
				cnt_q <= `SIWAI_CNT_ZERO;
			end
		end
	end
	assign cif.cnt = cnt_q;
endmodule : siwai_clk_counter
`default_nettype wire

// ==== rtl/siwai_core.sv ====
// wait, acknowledge and interrupt control of a two-wire / serial shift port
// assumes AXI4-Lite on sys_clk; scl/sda are open-drain pins from outside
`default_nettype none
`include "siwai_defs.svh"
module siwai_core
	import siwai_pkg::*;
#(
	parameter int ADDR_W   = 8,
	parameter int HALF_CYC = `SIWAI_SCL_HALF_NS / `SIWAI_CLK_PERIOD_NS
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              ce,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              scl_i,
	output logic                   scl_o,
	output logic                   scl_oe_n,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe_n
);
	localparam int DIV_W = $clog2(HALF_CYC + 1);
	localparam logic [ADDR_W-1:0] A_IRQ  = ADDR_W'(`SIWAI_IDX_IRQ_SEL << `SIWAI_WORD_SHIFT);
	localparam logic [ADDR_W-1:0] A_WAIT = ADDR_W'(`SIWAI_IDX_WAIT_CTRL << `SIWAI_WORD_SHIFT);
	localparam logic [ADDR_W-1:0] A_STAT = ADDR_W'(`SIWAI_IDX_STATUS << `SIWAI_WORD_SHIFT);
	localparam logic [ADDR_W-1:0] A_CFG  = ADDR_W'(`SIWAI_IDX_CONFIG << `SIWAI_WORD_SHIFT);

	// synchronised pins
	logic [1:0] pin_lvl;
	logic [1:0] pin_rise;
	logic [1:0] pin_fall;
	siwai_pin_sync #(.W(2)) u_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ce      (ce),
		.pin_i   ({sda_i, scl_i}),
		.lvl     (pin_lvl),
		.rise    (pin_rise),
		.fall    (pin_fall)
	);
	wire scl_s    = pin_lvl[0];
	wire scl_rise = pin_rise[0];
	wire scl_fall = pin_fall[0];
	wire sda_s    = pin_lvl[1];
	wire sda_rise = pin_rise[1];
	wire sda_fall = pin_fall[1];

	// register and state storage
	logic [1:0]        irq_sel_q;
	logic [1:0]        wait_sel_q;
	logic              ack_q;
	logic              rel_q;
	logic              i2c_q;
	logic              master_q;
	logic              tx_q;
	logic              irq_q;
	logic              cond_q;
	logic              start_q;
	logic              stop_q;
	logic              hold_q;
	logic              pulse_q;
	logic              ack_drv_q;
	logic              mclk_q;
	logic [DIV_W-1:0]  div_q;
	siwai_wait_t       state_q;

	// bus slave and pin driver storage
	logic              awready_q;
	logic              wready_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              arready_q;
	logic              rvalid_q;
	logic [1:0]        rresp_q;
	logic [31:0]       rdata_q;
	logic              scl_o_q;
	logic              scl_oe_n_q;
	logic              sda_oe_n_q;

	siwai_cnt_if cif ();
	siwai_clk_counter u_cnt (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ce      (ce),
		.cif     (cif.counter)
	);
	wire siwai_count_t cnt = cif.cnt;

	// write decode: both halves held, response slot free
	wire aw_hs    = s_axi_awvalid & awready_q;
	wire w_hs     = s_axi_wvalid & wready_q;
	wire b_hs     = bvalid_q & s_axi_bready;
	wire ar_hs    = s_axi_arvalid & arready_q;
	wire r_hs     = rvalid_q & s_axi_rready;
	wire do_write = ~awready_q & ~wready_q & ~bvalid_q;
	wire wr_lane  = do_write & wstrb_q[0];
	wire hit_irq  = awaddr_q == A_IRQ;
	wire hit_wait = awaddr_q == A_WAIT;
	wire hit_stat = awaddr_q == A_STAT;
	wire hit_cfg  = awaddr_q == A_CFG;
	wire wr_hit   = hit_irq | hit_wait | hit_stat | hit_cfg;
	wire wr_irq   = wr_lane & hit_irq;
	wire wr_wait  = wr_lane & hit_wait;
	wire wr_stat  = wr_lane & hit_stat;
	wire wr_cfg   = wr_lane & hit_cfg;

	// control events from software
	wire wr_release = wr_wait & wdata_q[`SIWAI_WC_REL];
	wire wr_force   = wr_wait & ~wdata_q[`SIWAI_WC_REL];
	wire clk_stop   = wr_cfg & wdata_q[`SIWAI_CF_CLKSTOP];
	wire i2c_drop   = wr_cfg & i2c_q & ~wdata_q[`SIWAI_CF_I2C];
	wire irq_clr    = wr_stat & wdata_q[`SIWAI_ST_IRQ];

	// bus conditions, only while clock high
	wire start_det = i2c_q & scl_s & sda_fall;
	wire stop_det  = i2c_q & scl_s & sda_rise;

	// wait condition at a falling shift clock edge
	wire at_eight  = cnt == `SIWAI_CNT_EIGHT;
	wire at_nine   = cnt == `SIWAI_CNT_I2C_MAX;
	wire at_seven  = cnt == `SIWAI_CNT_IRQ7;
	wire hit_data  = wait_sel_q == `SIWAI_WAIT_DATA && at_eight;
	wire hit_ack   = i2c_q && wait_sel_q == `SIWAI_WAIT_ACK && at_nine;
	wire hit_addr  = i2c_q && wait_sel_q == `SIWAI_WAIT_ADDR && start_q && at_eight;
	wire wait_hit  = hit_data | hit_ack | hit_addr;
	wire in_run    = state_q != st_wait;
	wire run       = in_run | pulse_q;
	wire enter_wait = scl_fall & ((state_q == st_force) | (state_q == st_run & wait_hit));
	wire pulse_end  = i2c_q ? scl_fall : scl_rise;

	// master clock generation; a low line while released is a slave wait
	wire mclk_act   = master_q & run;
	wire div_last   = div_q == DIV_W'(HALF_CYC - 1);
	wire stretched  = i2c_q & mclk_q & ~scl_s;
	wire slave_wait = master_q & in_run & stretched;
	wire wait_flag  = in_run & ~slave_wait;

	// pin drive decisions
	wire slave_hold = hold_q & (state_q == st_wait);
	wire scl_pull   = i2c_q & (master_q ? ~mclk_q : slave_hold);
	wire scl_oe_n_d = i2c_q ? ~scl_pull : ~master_q;
	wire scl_o_d    = ~i2c_q & mclk_q;
	wire ack_start  = i2c_q & ~tx_q & run & scl_fall & at_eight;
	wire ack_sample = i2c_q & tx_q & run & scl_rise & at_eight;

	// interrupt condition, level; a rising level sets the flag
	wire cond_cnt7  = irq_sel_q == `SIWAI_IRQ_CNT7 && at_seven;
	wire cond_cnt8  = irq_sel_q == `SIWAI_IRQ_CNT8 && at_eight;
	wire cond_st7   = irq_sel_q == `SIWAI_IRQ_START7 && i2c_q && start_q && at_seven;
	wire cond_stop  = irq_sel_q == `SIWAI_IRQ_STOP && i2c_q && stop_q;
	wire cond       = cond_cnt7 | cond_cnt8 | cond_st7 | cond_stop;
	wire irq_set    = cond & ~cond_q;

	assign cif.rise = scl_rise;
	assign cif.fall = scl_fall;
	assign cif.run  = run;
	assign cif.clr  = clk_stop | start_det | i2c_drop | (wr_wait & ~i2c_q);
	assign cif.i2c  = i2c_q;

	// read mux
	wire [31:0] rd_irq  = {30'h0, irq_sel_q};
	wire [31:0] rd_wait = {28'h0, ack_q, wait_flag, wait_sel_q};
	wire [31:0] rd_stat = {23'h0, rel_q, cnt, stop_q, start_q, wait_flag, irq_q};
	wire [31:0] rd_cfg  = {29'h0, tx_q, master_q, i2c_q};
	wire        r_irq   = s_axi_araddr == A_IRQ;
	wire        r_wait  = s_axi_araddr == A_WAIT;
	wire        r_stat  = s_axi_araddr == A_STAT;
	wire        r_cfg   = s_axi_araddr == A_CFG;
	wire        r_hit   = r_irq | r_wait | r_stat | r_cfg;
	wire [31:0] rd_word = r_irq ? rd_irq : r_wait ? rd_wait : r_stat ? rd_stat :
		r_cfg ? rd_cfg : 32'h0;

	// write channel slave
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			bresp_q   <= `SIWAI_RESP_OKAY;
			awaddr_q  <= '0;
			wdata_q   <= 32'h0;
			wstrb_q   <= 4'h0;
		end else if (ce) begin
			if (aw_hs) begin
				awaddr_q  <= s_axi_awaddr;
				awready_q <= 1'b0;
			end
			if (w_hs) begin
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
				wready_q <= 1'b0;
			end
			if (do_write) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_hit ? `SIWAI_RESP_OKAY : `SIWAI_RESP_SLVERR;
			end
			if (b_hs) begin
				bvalid_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end

	// read channel slave
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rresp_q   <= `SIWAI_RESP_OKAY;
			rdata_q   <= 32'h0;
		end else if (ce) begin
			if (ar_hs) begin
				arready_q <= 1'b0;
				rvalid_q  <= 1'b1;
				rdata_q   <= rd_word;
				rresp_q   <= r_hit ? `SIWAI_RESP_OKAY : `SIWAI_RESP_SLVERR;
			end else if (r_hs) begin
				rvalid_q  <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	// mode configuration
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			i2c_q    <= 1'b0;
			master_q <= 1'b0;
			tx_q     <= 1'b0;
		end else if (ce && wr_cfg) begin
			i2c_q    <= wdata_q[`SIWAI_CF_I2C];
			master_q <= wdata_q[`SIWAI_CF_MASTER];
			tx_q     <= wdata_q[`SIWAI_CF_TX];
		end
	end

	// selections; clock stop returns them to reset value
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_sel_q  <= 2'h0;
			wait_sel_q <= 2'h0;
			rel_q      <= 1'b0;
		end else if (ce) begin
			if (clk_stop) begin
				irq_sel_q  <= 2'h0;
				wait_sel_q <= 2'h0;
				rel_q      <= 1'b0;
			end else begin
				if (wr_irq) begin
					irq_sel_q <= wdata_q[1:0];
				end
				if (wr_wait) begin
					wait_sel_q <= wdata_q[1:0];
					rel_q      <= wdata_q[`SIWAI_WC_REL];
				end
			end
		end
	end

	// acknowledge bit: hardware sample beats a same-cycle write
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else if (ce) begin
			if (clk_stop) begin
				ack_q <= 1'b0;
			end else if (ack_sample) begin
				ack_q <= sda_s;
			end else if (wr_wait) begin
				ack_q <= wdata_q[`SIWAI_WC_ACK];
			end
		end
	end

	// acknowledge drive window: from fall at count 8 to the next fall
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ack_drv_q <= 1'b0;
		end else if (ce) begin
			if (!i2c_q || tx_q) begin
				ack_drv_q <= 1'b0;
			end else if (scl_fall) begin
				ack_drv_q <= ack_start;
			end
		end
	end

	// wait state machine
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= st_wait;
		end else if (ce) begin
			case (state_q)
				st_wait: begin
					if (wr_release && !clk_stop) begin
						state_q <= st_run;
					end
				end
				st_run: begin
					if (clk_stop) begin
						state_q <= st_wait;
					end else if (wr_force) begin
						state_q <= st_force;
					end else if (enter_wait) begin
						state_q <= st_wait;
					end
				end
				st_force: begin
					if (clk_stop) begin
						state_q <= st_wait;
					end else if (wr_release) begin
						state_q <= st_run;
					end else if (enter_wait) begin
						state_q <= st_wait;
					end
				end
				default: begin
					state_q <= st_wait;
				end
			endcase
		end
	end

	// clock hold after a wait entry, and one-pulse request
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hold_q  <= 1'b0;
			pulse_q <= 1'b0;
		end else if (ce) begin
			if (clk_stop || wr_release) begin
				hold_q <= 1'b0;
			end else if (enter_wait) begin
				hold_q <= 1'b1;
			end
			if (clk_stop || (pulse_q && pulse_end)) begin
				pulse_q <= 1'b0;
			end else if (wr_force && state_q == st_wait && master_q) begin
				pulse_q <= 1'b1;
			end
		end
	end

	// master shift clock divider
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mclk_q <= 1'b1;
			div_q  <= '0;
		end else if (ce) begin
			if (!mclk_act) begin
				mclk_q <= ~i2c_q;
				div_q  <= '0;
			end else if (stretched) begin
				div_q <= '0;
			end else if (div_last) begin
				mclk_q <= ~mclk_q;
				div_q  <= '0;
			end else begin
				div_q <= div_q + DIV_W'(1);
			end
		end
	end

	// interrupt flag: a set in the clearing cycle wins
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cond_q <= 1'b0;
			irq_q  <= 1'b0;
		end else if (ce) begin
			cond_q <= cond;
			if (irq_set) begin
				irq_q <= 1'b1;
			end else if (irq_clr) begin
				irq_q <= 1'b0;
			end
		end
	end

	// start and stop seen flags, zero outside two-wire mode
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			start_q <= 1'b0;
			stop_q  <= 1'b0;
		end else if (ce) begin
			if (!i2c_q) begin
				start_q <= 1'b0;
				stop_q  <= 1'b0;
			end else if (start_det) begin
				start_q <= 1'b1;
				stop_q  <= 1'b0;
			end else if (stop_det) begin
				start_q <= 1'b0;
				stop_q  <= 1'b1;
			end
		end
	end

	// registered pin drivers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scl_o_q    <= 1'b0;
			scl_oe_n_q <= 1'b1;
			sda_oe_n_q <= 1'b1;
		end else if (ce) begin
			scl_o_q    <= scl_o_d;
			scl_oe_n_q <= scl_oe_n_d;
			sda_oe_n_q <= ~(ack_drv_q & ~ack_q);
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign scl_o         = scl_o_q;
	assign scl_oe_n      = scl_oe_n_q;
	assign sda_o         = 1'b0;
	assign sda_oe_n      = sda_oe_n_q;
endmodule : siwai_core
`default_nettype wire

// ==== bench/siwai_props.sv ====
// checker for bus handshakes and acknowledge drive timing of siwai_core
// assumes ce drops only while the register bus is idle; bound to every siwai_core
`default_nettype none
module siwai_props #(
	parameter int ADDR_W = 8
) (
	input wire logic              sys_clk,
	input wire logic              rst,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic              scl_i,
	input wire logic              sda_oe_n
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_w_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|=> !s_axi_awready ##1 s_axi_bvalid;
	endproperty
	a_w_lat: assert property (p_w_lat) else $error("write answer late");
	property p_r_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_r_lat: assert property (p_r_lat) else $error("read answer late");
	property p_r_done;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
	endproperty
	a_r_done: assert property (p_r_done) else $error("read not closed");
	property p_b_done;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
	endproperty
	a_b_done: assert property (p_b_done) else $error("write not closed");
	property p_unmapped;
		s_axi_arvalid && s_axi_arready && !(s_axi_araddr inside {8'h30, 8'h38, 8'h3C, 8'h40})
			|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
	property p_ack_edge;
		$changed(sda_oe_n) |-> !scl_i && $past(scl_i, 2) == 1'h0;
	endproperty
	a_ack_edge: assert property (p_ack_edge)
		else $error("data drive moved outside clock low");
endmodule : siwai_props
bind siwai_core siwai_props #(.ADDR_W(ADDR_W)) u_props (.sys_clk(sys_clk), .rst(rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .scl_i(scl_i), .sda_oe_n(sda_oe_n));
`default_nettype wire

// ==== bench/siwai_i2c_station.sv ====
// behavioural two-wire master station pulling clock and data lines low
// assumes the bench resolves wired levels with pull-ups
`default_nettype none
module siwai_i2c_station (
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_low,
	output logic      sda_low
);
	timeunit 1ns;
	timeprecision 100ps;
	int slow = 0;
	initial begin
		scl_low = 1'h0;
		sda_low = 1'h0;
	end
	task automatic pulse(input logic v, output logic seen);
		sda_low = !v;
		#31;
		scl_low = 1'h0;
		wait (scl_i === 1'h1);
		#(31 + slow);
		seen = sda_i;
		#31;
		scl_low = 1'h1;
		#31;
	endtask : pulse
	task automatic start_cond;
		sda_low = 1'h1;
		#62;
		scl_low = 1'h1;
		#31;
	endtask : start_cond
	task automatic stop_cond;
		sda_low = 1'h1;
		#31;
		scl_low = 1'h0;
		#62;
		sda_low = 1'h0;
		#62;
	endtask : stop_cond
	task automatic clocks(input int n);
		logic s;
		repeat (n) pulse(1'h1, s);
	endtask : clocks
	task automatic send_byte(input logic [7:0] b, input logic nine, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) pulse(b[i], s);
		pulse(nine, ack);
	endtask : send_byte
endmodule : siwai_i2c_station
`default_nettype wire

// ==== bench/siwai_core_tb_top.sv ====
// bench: register bus tasks with expectation queues, two-wire station
// assumes siwai_core and its defs header; master half period shortened
`default_nettype none
`include "siwai_defs.svh"
module siwai_core_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic [31:0] m; logic [31:0] v; logic [1:0] r;} siwai_exp_t;
	localparam logic [7:0] ad_irq  = 8'(`SIWAI_IDX_IRQ_SEL << `SIWAI_WORD_SHIFT);
	localparam logic [7:0] ad_wait = 8'(`SIWAI_IDX_WAIT_CTRL << `SIWAI_WORD_SHIFT);
	localparam logic [7:0] ad_stat = 8'(`SIWAI_IDX_STATUS << `SIWAI_WORD_SHIFT);
	localparam logic [7:0] ad_cfg  = 8'(`SIWAI_IDX_CONFIG << `SIWAI_WORD_SHIFT);
	logic        sys_clk = 1'h0, rst = 1'h1, ce = 1'h1;
	logic [3:0]  wstrb = 4'hF;
	logic [7:0]  awaddr = 8'h0, araddr = 8'h0, d;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic        awready, wready, bvalid, arready, rvalid, ack;
	logic        scl_o, scl_oe_n, sda_o, sda_oe_n, scl_low, sda_low;
	logic [1:0]  bresp, rresp;
	wire logic   scl = !(scl_low || (!scl_oe_n && !scl_o));
	wire logic   sda = !(sda_low || (!sda_oe_n && !sda_o));
	siwai_exp_t  rq[$], e;
	logic [1:0]  bq[$];
	int          bad_count = 0, checks_done = 0, cyc = 0, k;
	siwai_core #(.HALF_CYC(4)) dut (.sys_clk(sys_clk), .rst(rst), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
		.sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
	siwai_i2c_station m (.scl_i(scl), .sda_i(sda), .scl_low(scl_low), .sda_low(sda_low));
	always #2.5 sys_clk = !sys_clk;
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h wanted %h", $time, got, exp);
		end
	endtask : chk
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
		bq.push_back(r);
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!bvalid);
		bready <= 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] v,
			input logic [1:0] r = 2'h0);
		rq.push_back(siwai_exp_t'{mk, v & mk, r});
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'h0;
		end while (!rvalid);
		rready <= 1'h0;
	endtask : rd
	// result watcher: oldest note against each answer
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (rvalid && rready) begin
			e = rq.pop_front();
			chk({rresp, rdata & e.m}, {e.r, e.v});
		end
		if (bvalid && bready) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
		if (cyc == 60000) begin
			bad_count++;
			give_verdict();
		end
	end
	initial begin
		void'($urandom(71));
		repeat (6) @(posedge sys_clk);
		rst <= 1'h0;
		rd(ad_irq, 32'hFFFFFFFF, 32'h0);
		rd(ad_wait, 32'hFFFFFFFF, 32'h0);
		rd(ad_stat, 32'hFFFFFFFF, 32'h0);
		rd(ad_cfg, 32'hFFFFFFFF, 32'h0);
		rd(8'h34, 32'hFFFFFFFF, 32'h0, 2'h2);
		wr(8'h34, 32'h1, 2'h2);
		wstrb <= 4'hE;
		wr(ad_irq, 32'h3, 2'h0);
		wstrb <= 4'hF;
		rd(ad_irq, 32'h3, 32'h0);
		wr(ad_irq, 32'h3, 2'h0);
		rd(ad_irq, 32'h3, 32'h3);
		$display("test registers done");
		wr(ad_cfg, 32'h1, 2'h0);
		wr(ad_wait, 32'h4, 2'h0);
		m.start_cond();
		rd(ad_stat, 32'hF4, 32'h4);
		d = 8'($urandom);
		m.send_byte(d, 1'h1, ack);
		chk({33'h0, ack}, 34'h0);
		rd(ad_stat, 32'hF0, 32'h0);
		wr(ad_wait, 32'hC, 2'h0);
		m.slow = 250;
		repeat (2) begin
			m.send_byte(8'($urandom), 1'h1, ack);
			chk({33'h0, ack}, 34'h1);
		end
		m.slow = 0;
		wr(ad_cfg, 32'h5, 2'h0);
		m.send_byte(8'($urandom), 1'h0, ack);
		rd(ad_wait, 32'h8, 32'h0);
		wr(ad_cfg, 32'h1, 2'h0);
		k = 1 + ($urandom % 8);
		m.clocks(k);
		rd(ad_stat, 32'hF0, 32'(k) << 4);
		ce <= 1'h0;
		m.clocks(1);
		@(posedge sys_clk);
		ce <= 1'h1;
		rd(ad_stat, 32'hF0, 32'(k) << 4);
		m.clocks(9 - k);
		$display("test link done");
		for (int c = 0; c < 2; c++) begin
			wr(ad_irq, 32'(c ^ 1), 2'h0);
			m.clocks(7 + c);
			wr(ad_stat, 32'h1, 2'h0);
			rd(ad_stat, 32'h1, 32'h0);
			wr(ad_irq, 32'(c), 2'h0);
			rd(ad_stat, 32'h1, 32'h1);
			m.clocks(2 - c);
		end
		wr(ad_irq, 32'h2, 2'h0);
		m.stop_cond();
		m.start_cond();
		wr(ad_stat, 32'h1, 2'h0);
		m.clocks(7);
		rd(ad_stat, 32'h1, 32'h1);
		m.clocks(2);
		m.stop_cond();
		wr(ad_stat, 32'h1, 2'h0);
		wr(ad_irq, 32'h3, 2'h0);
		rd(ad_stat, 32'h9, 32'h9);
		m.start_cond();
		m.clocks(3);
		wr(ad_cfg, 32'h0, 2'h0);
		rd(ad_stat, 32'hF0, 32'h0);
		wr(ad_irq, 32'h2, 2'h0);
		wr(ad_stat, 32'h1, 2'h0);
		m.clocks(9);
		rd(ad_stat, 32'hF1, 32'h10);
		m.stop_cond();
		$display("test interrupts done");
		wr(ad_cfg, 32'h1, 2'h0);
		m.start_cond();
		wr(ad_wait, 32'h5, 2'h0);
		m.clocks(8);
		repeat (20) @(posedge sys_clk);
		chk({32'h0, scl_oe_n, sda_oe_n}, 34'h0);
		rd(ad_stat, 32'hF2, 32'h80);
		wr(ad_wait, 32'h4, 2'h0);
		wr(ad_wait, 32'h4, 2'h0);
		m.clocks(1);
		rd(ad_stat, 32'hF2, 32'h2);
		wr(ad_wait, 32'h6, 2'h0);
		m.clocks(9);
		rd(ad_stat, 32'hF2, 32'h0);
		wr(ad_wait, 32'h4, 2'h0);
		wr(ad_wait, 32'h0, 2'h0);
		m.clocks(1);
		repeat (20) @(posedge sys_clk);
		chk({33'h0, scl_oe_n}, 34'h0);
		rd(ad_stat, 32'hF2, 32'h10);
		wr(ad_wait, 32'hC, 2'h0);
		m.stop_cond();
		wr(ad_cfg, 32'h9, 2'h0);
		rd(ad_stat, 32'hF2, 32'h0);
		rd(ad_irq, 32'h3, 32'h0);
		$display("test wait done");
		give_verdict();
	end
endmodule : siwai_core_tb_top
`default_nettype wire
